// [port0_gpio.sv]
// port 0 gpio block with AXI4-Lite register slave
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`timescale 1ns/100ps
`default_nettype none
module port0_gpio
(
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic [11:0] I_AWADDR,
  input wire logic I_AWVALID,
  output logic O_AWREADY,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  input wire logic I_WVALID,
  output logic O_WREADY,
  output logic [1:0] O_BRESP,
  output logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic [11:0] I_ARADDR,
  input wire logic [2:0] I_ARPROT,
  input wire logic I_ARVALID,
  output logic O_ARREADY,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  output logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [7:0] I_PIN_IN,
  output logic [7:0] O_PIN_OUT,
  output logic [7:0] O_PIN_OE,
  output logic [7:0] O_PULLUP_ON,
  output logic [7:0] O_DIG_IN_EN,
  output logic [7:0] O_DIG_IN,
  output logic [7:0] O_EXT_IRQ_LEVEL,
  input wire logic [7:0] I_PERIPH_OE,
  input wire logic [7:0] I_PERIPH_OUT,
  input wire logic I_STANDBY_PIN_STATE_SELECT,
  input wire logic I_STOP_OR_WATCH,
  input wire logic [7:0] I_EXT_IRQ_ENABLE
);
  typedef struct packed {
    port0_pkg::port_regs_s regs;
    port0_pkg::pin_ctrl_s pins;
    logic [7:0] dig_in;
    logic aw_held;
    logic [11:0] aw_addr;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic last_rmw;
    logic awready;
    logic wready;
    logic arready;
  } top_state_s;

  top_state_s state_q;
  top_state_s state_d;
  logic [7:0] pin_sync;
  logic [7:0] mux_out;
  logic [7:0] mux_oe;
  logic [7:0] mux_pullup;
  logic [7:0] mux_dig_en;
  logic [7:0] mux_irq;
  logic standby_hiz;
  logic [7:0] sampled_pin;
  logic [7:0] data_read_value;
  logic rmw_access;
  logic [9:0] aw_word;
  logic [9:0] ar_word;
  logic [5:0] wr_sel;
  logic [5:0] rd_sel;

  assign standby_hiz = I_STANDBY_PIN_STATE_SELECT && I_STOP_OR_WATCH;
  // read qualifier carried on the privileged bit (bit 0) of arprot
  assign rmw_access = I_ARPROT[port0_pkg::RMW_BIT];
  assign aw_word = state_q.aw_addr[11:port0_pkg::ADDR_LSB];
  assign ar_word = I_ARADDR[11:port0_pkg::ADDR_LSB];

  // one-hot word decode: latch, direction, pull-up, analog, pin level, rmw flag
  always_comb
  begin
    wr_sel = 6'h00;
    if (aw_word == port0_pkg::OFF_DATA_LATCH[11:port0_pkg::ADDR_LSB])
    begin
      wr_sel[0] = 1'b1;
    end
    else if (aw_word == port0_pkg::OFF_DIRECTION[11:port0_pkg::ADDR_LSB])
    begin
      wr_sel[1] = 1'b1;
    end
    else if (aw_word == port0_pkg::OFF_PULLUP_ENABLE[11:port0_pkg::ADDR_LSB])
    begin
      wr_sel[2] = 1'b1;
    end
    else if (aw_word == port0_pkg::OFF_ANALOG_INPUT_DISABLE[11:port0_pkg::ADDR_LSB])
    begin
      wr_sel[3] = 1'b1;
    end
    else if (aw_word == port0_pkg::OFF_PIN_LEVEL[11:port0_pkg::ADDR_LSB])
    begin
      wr_sel[4] = 1'b1;
    end
    else if (aw_word == port0_pkg::OFF_RMW_STATUS[11:port0_pkg::ADDR_LSB])
    begin
      wr_sel[5] = 1'b1;
    end
    rd_sel = 6'h00;
    if (ar_word == port0_pkg::OFF_DATA_LATCH[11:port0_pkg::ADDR_LSB])
    begin
      rd_sel[0] = 1'b1;
    end
    else if (ar_word == port0_pkg::OFF_DIRECTION[11:port0_pkg::ADDR_LSB])
    begin
      rd_sel[1] = 1'b1;
    end
    else if (ar_word == port0_pkg::OFF_PULLUP_ENABLE[11:port0_pkg::ADDR_LSB])
    begin
      rd_sel[2] = 1'b1;
    end
    else if (ar_word == port0_pkg::OFF_ANALOG_INPUT_DISABLE[11:port0_pkg::ADDR_LSB])
    begin
      rd_sel[3] = 1'b1;
    end
    else if (ar_word == port0_pkg::OFF_PIN_LEVEL[11:port0_pkg::ADDR_LSB])
    begin
      rd_sel[4] = 1'b1;
    end
    else if (ar_word == port0_pkg::OFF_RMW_STATUS[11:port0_pkg::ADDR_LSB])
    begin
      rd_sel[5] = 1'b1;
    end
  end

  for (genvar n = 0; n < port0_pkg::PIN_COUNT; n++)
  begin : g_pin
    port0_pin_sync u_sync
    (
      .i_clk(I_CLK_SYS),
      .i_rst(I_RST),
      .i_async(I_PIN_IN[n]),
      .o_level(pin_sync[n])
    );
    // bit n of every register steers pin n
    port0_pin_mux u_mux
    (
      .i_latch(state_q.regs.data_latch[n]),
      .i_direction(state_q.regs.direction[n]),
      .i_pullup_enable(state_q.regs.pullup_enable[n]),
      .i_analog_disable(state_q.regs.analog_input_disable_low[n]),
      .i_periph_oe(I_PERIPH_OE[n]),
      .i_periph_out(I_PERIPH_OUT[n]),
      .i_standby_hiz(standby_hiz),
      .i_irq_enable(I_EXT_IRQ_ENABLE[n]),
      .i_pin_level(pin_sync[n]),
      .o_out(mux_out[n]),
      .o_oe(mux_oe[n]),
      .o_pullup(mux_pullup[n]),
      .o_dig_in_en(mux_dig_en[n]),
      .o_irq_level(mux_irq[n])
    );
  end

  always_comb
  begin
    sampled_pin = pin_sync & state_q.pins.digital_input_enable;
    for (int i = 0; i < port0_pkg::PIN_COUNT; i++)
    begin
      if (rmw_access || (state_q.regs.direction[i] && !I_PERIPH_OE[i]))
      begin
        data_read_value[i] = state_q.regs.data_latch[i];
      end
      else
      begin
        data_read_value[i] = sampled_pin[i];
      end
    end
  end

  always_comb
  begin
    state_d = state_q;
    state_d.pins.out_value = mux_out;
    state_d.pins.out_enable = mux_oe;
    state_d.pins.pullup_on = mux_pullup;
    state_d.pins.digital_input_enable = mux_dig_en;
    state_d.pins.ext_irq_level = mux_irq;
    state_d.dig_in = sampled_pin;
    if (I_AWVALID && state_q.awready)
    begin
      state_d.aw_held = 1'b1;
      state_d.aw_addr = I_AWADDR;
    end
    if (I_WVALID && state_q.wready)
    begin
      state_d.w_held = 1'b1;
      state_d.w_data = I_WDATA;
      state_d.w_strb = I_WSTRB;
    end
    if (state_q.bvalid && I_BREADY)
    begin
      state_d.bvalid = 1'b0;
    end
    if (state_q.aw_held && state_q.w_held && !state_q.bvalid)
    begin
      state_d.aw_held = 1'b0;
      state_d.w_held = 1'b0;
      state_d.bvalid = 1'b1;
      state_d.bresp = port0_pkg::RESP_OKAY;
      if (wr_sel[0])
      begin
        if (state_q.w_strb[0])
        begin
          // latch written for inputs and outputs alike
          state_d.regs.data_latch = state_q.w_data[7:0];
        end
      end
      else if (wr_sel[1])
      begin
        if (state_q.w_strb[0])
        begin
          state_d.regs.direction = state_q.w_data[7:0];
        end
      end
      else if (wr_sel[2])
      begin
        if (state_q.w_strb[0])
        begin
          state_d.regs.pullup_enable = state_q.w_data[7:0];
        end
      end
      else if (wr_sel[3])
      begin
        if (state_q.w_strb[0])
        begin
          state_d.regs.analog_input_disable_low = state_q.w_data[7:0];
        end
      end
      else if (wr_sel[4] || wr_sel[5])
      begin
        state_d.bresp = port0_pkg::RESP_OKAY;
      end
      else
      begin
        state_d.bresp = port0_pkg::RESP_SLVERR;
      end
    end
    if (state_q.rvalid && I_RREADY)
    begin
      state_d.rvalid = 1'b0;
    end
    if (I_ARVALID && state_q.arready)
    begin
      state_d.rvalid = 1'b1;
      state_d.rresp = port0_pkg::RESP_OKAY;
      state_d.rdata = 32'h0000_0000;
      if (rd_sel[0])
      begin
        state_d.rdata[7:0] = data_read_value;
        state_d.last_rmw = rmw_access;
      end
      else if (rd_sel[1])
      begin
        state_d.rdata[7:0] = state_q.regs.direction;
      end
      else if (rd_sel[2])
      begin
        state_d.rdata[7:0] = state_q.regs.pullup_enable;
      end
      else if (rd_sel[3])
      begin
        state_d.rdata[7:0] = state_q.regs.analog_input_disable_low;
      end
      else if (rd_sel[4])
      begin
        state_d.rdata[7:0] = pin_sync;
      end
      else if (rd_sel[5])
      begin
        state_d.rdata[0] = state_q.last_rmw;
      end
      else
      begin
        state_d.rresp = port0_pkg::RESP_SLVERR;
      end
    end
    state_d.awready = !state_d.aw_held;
    state_d.wready = !state_d.w_held;
    state_d.arready = !state_d.rvalid;
  end

  always_ff @(posedge I_CLK_SYS)
  begin
    if (I_RST)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ready levels are registered: high only while a slot is free
  assign O_AWREADY = state_q.awready;
  assign O_WREADY = state_q.wready;
  assign O_ARREADY = state_q.arready;
  assign O_BVALID = state_q.bvalid;
  assign O_BRESP = state_q.bresp;
  assign O_RVALID = state_q.rvalid;
  assign O_RDATA = state_q.rdata;
  assign O_RRESP = state_q.rresp;
  assign O_PIN_OUT = state_q.pins.out_value;
  assign O_PIN_OE = state_q.pins.out_enable;
  assign O_PULLUP_ON = state_q.pins.pullup_on;
  assign O_DIG_IN_EN = state_q.pins.digital_input_enable;
  assign O_DIG_IN = state_q.dig_in;
  assign O_EXT_IRQ_LEVEL = state_q.pins.ext_irq_level;
endmodule : port0_gpio
`default_nettype wire

// [port0_gpio_checker.sv]
// assertions on the port 0 block ports
`timescale 1ns/100ps
`default_nettype none
module port0_gpio_checker
(
  input wire logic I_CLK_SYS,
  input wire logic I_RST,
  input wire logic I_AWVALID,
  input wire logic O_AWREADY,
  input wire logic I_WVALID,
  input wire logic O_WREADY,
  input wire logic [1:0] O_BRESP,
  input wire logic O_BVALID,
  input wire logic I_BREADY,
  input wire logic I_ARVALID,
  input wire logic O_ARREADY,
  input wire logic [31:0] O_RDATA,
  input wire logic O_RVALID,
  input wire logic I_RREADY,
  input wire logic [7:0] O_PIN_OUT,
  input wire logic [7:0] O_PIN_OE,
  input wire logic [7:0] O_PULLUP_ON,
  input wire logic [7:0] I_PERIPH_OE,
  input wire logic [7:0] I_PERIPH_OUT,
  input wire logic I_STANDBY_PIN_STATE_SELECT,
  input wire logic I_STOP_OR_WATCH
);
  logic sb;
  assign sb = I_STANDBY_PIN_STATE_SELECT && I_STOP_OR_WATCH;
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RST);
  sequence wr_taken;
    !O_BVALID && I_AWVALID && O_AWREADY && I_WVALID && O_WREADY;
  endsequence
  sequence wr_answer;
    ##2 O_BVALID;
  endsequence
  write_answer_a: assert property (wr_taken |-> wr_answer)
    else $error("write response late");
  read_answer_a: assert property (
    I_ARVALID && O_ARREADY |=> O_RVALID && O_RDATA[31:8] == 24'h000000)
    else $error("read answer late or wide");
  bresp_hold_a: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
    else $error("write response dropped");
  rdata_hold_a: assert property (O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("read data dropped");
  read_refuse_a: assert property (O_RVALID |-> !O_ARREADY)
    else $error("address taken during answer");
  periph_takeover_a: assert property (
    !$past(I_RST) && !$past(sb) |->
      ((O_PIN_OE & $past(I_PERIPH_OE)) == $past(I_PERIPH_OE)) &&
      (((O_PIN_OUT ^ $past(I_PERIPH_OUT)) & $past(I_PERIPH_OE)) == 8'h00))
    else $error("peripheral not driving pin");
  standby_float_a: assert property ($past(sb) |-> O_PIN_OE == 8'h00)
    else $error("pin driven in standby");
  pullup_low_a: assert property ((O_PULLUP_ON & O_PIN_OE & ~O_PIN_OUT) == 8'h00)
    else $error("pull-up on low pin");
endmodule : port0_gpio_checker
bind port0_gpio port0_gpio_checker u_checker (.*);
`default_nettype wire

// [port0_gpio_test.sv]
// self-checking bench for the port 0 block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      fails++; \
      $display("unexpected %0t: got %h want %h", $time, g, e); \
    end \
  end
module port0_gpio_test;
  logic I_CLK_SYS, I_RST, I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY;
  logic I_STANDBY_PIN_STATE_SELECT, I_STOP_OR_WATCH, O_AWREADY, O_WREADY;
  logic O_BVALID, O_ARREADY, O_RVALID;
  logic [11:0] I_AWADDR, I_ARADDR;
  logic [31:0] I_WDATA, O_RDATA, d;
  logic [3:0] I_WSTRB;
  logic [2:0] I_ARPROT;
  logic [1:0] O_BRESP, O_RRESP, r;
  logic [7:0] I_PIN_IN, O_PIN_OUT, O_PIN_OE, O_PULLUP_ON, O_DIG_IN_EN, O_DIG_IN;
  logic [7:0] O_EXT_IRQ_LEVEL, I_PERIPH_OE, I_PERIPH_OUT, I_EXT_IRQ_ENABLE, ext_val, ext_oe;
  int fails, samples_checked;
  port0_gpio u_dut (.*);
  port0_pin_model u_pins (.i_clk(I_CLK_SYS), .i_out(O_PIN_OUT), .i_oe(O_PIN_OE),
    .i_pullup(O_PULLUP_ON), .i_ext_val(ext_val), .i_ext_oe(ext_oe), .o_level(I_PIN_IN));
  task automatic results;
    if (fails == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  task automatic wr(input logic [11:0] a, input logic [7:0] v, output logic [1:0] rs);
    logic ta, tw;
    int t;
    I_AWADDR <= a;
    I_WDATA <= {24'h000000, v};
    I_AWVALID <= 1'b1;
    I_WVALID <= 1'b1;
    ta = 1'b0;
    tw = 1'b0;
    for (t = 0; t < 30 && !(ta && tw); t++)
    begin
      @(negedge I_CLK_SYS);
      ta |= O_AWREADY;
      tw |= O_WREADY;
      @(posedge I_CLK_SYS);
      if (ta) I_AWVALID <= 1'b0;
      if (tw) I_WVALID <= 1'b0;
    end
    for (t = 0; t < 30 && !O_BVALID; t++)
      @(negedge I_CLK_SYS);
    if (!O_BVALID)
    begin
      fails++;
      $display("unexpected %0t: write response missing", $time);
    end
    rs = O_BRESP;
    @(posedge I_CLK_SYS);
    I_BREADY <= 1'b1;
    @(posedge I_CLK_SYS);
    I_BREADY <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic p, output logic [31:0] v,
                    output logic [1:0] rs);
    logic ta;
    int t;
    I_ARADDR <= a;
    I_ARPROT <= {2'b00, p};
    I_ARVALID <= 1'b1;
    ta = 1'b0;
    for (t = 0; t < 30 && !ta; t++)
    begin
      @(negedge I_CLK_SYS);
      ta = O_ARREADY;
      @(posedge I_CLK_SYS);
      if (ta) I_ARVALID <= 1'b0;
    end
    for (t = 0; t < 30 && !O_RVALID; t++)
      @(negedge I_CLK_SYS);
    if (!O_RVALID)
    begin
      fails++;
      $display("unexpected %0t: read response missing", $time);
    end
    v = O_RDATA;
    rs = O_RRESP;
    @(posedge I_CLK_SYS);
    I_RREADY <= 1'b1;
    @(posedge I_CLK_SYS);
    I_RREADY <= 1'b0;
  endtask : rd
  task automatic wok(input logic [11:0] a, input logic [7:0] v);
    wr(a, v, r);
    `CHK(r, port0_pkg::RESP_OKAY)
  endtask : wok
  task automatic rchk(input logic [11:0] a, input logic p, input logic [7:0] e);
    rd(a, p, d, r);
    `CHK({r, d}, {port0_pkg::RESP_OKAY, 24'h000000, e})
  endtask : rchk
  task automatic settle;
    repeat (8) @(posedge I_CLK_SYS);
  endtask : settle
  task automatic t_out_in;
    rchk(port0_pkg::OFF_DIRECTION, 1'b0, 8'h00);
    rchk(port0_pkg::OFF_PULLUP_ENABLE, 1'b0, 8'h00);
    rchk(port0_pkg::OFF_ANALOG_INPUT_DISABLE, 1'b0, 8'h00);
    rchk(port0_pkg::OFF_DATA_LATCH, 1'b1, 8'h00);
    `CHK(O_DIG_IN_EN, 8'h00)
    `CHK(O_DIG_IN, 8'h00)
    wok(port0_pkg::OFF_DIRECTION, 8'hFF);
    wok(port0_pkg::OFF_DATA_LATCH, 8'hA5);
    wok(port0_pkg::OFF_PULLUP_ENABLE, 8'hFF);
    settle();
    `CHK({O_PIN_OE, O_PIN_OUT}, 16'hFFA5)
    `CHK(O_PULLUP_ON, 8'hA5)
    rchk(port0_pkg::OFF_DATA_LATCH, 1'b0, 8'hA5);
    wok(port0_pkg::OFF_PULLUP_ENABLE, 8'h00);
    wok(port0_pkg::OFF_DIRECTION, 8'h0F);
    wok(port0_pkg::OFF_ANALOG_INPUT_DISABLE, 8'hFF);
    wok(port0_pkg::OFF_DATA_LATCH, 8'h3C);
    ext_oe <= 8'hF0;
    ext_val <= 8'h90;
    settle();
    `CHK(O_PIN_OE, 8'h0F)
    `CHK(O_EXT_IRQ_LEVEL, 8'h9C)
    rchk(port0_pkg::OFF_PIN_LEVEL, 1'b0, 8'h9C);
    rchk(port0_pkg::OFF_DATA_LATCH, 1'b0, 8'h9C);
    rchk(port0_pkg::OFF_DATA_LATCH, 1'b1, 8'h3C);
    rchk(port0_pkg::OFF_RMW_STATUS, 1'b0, 8'h01);
    wok(port0_pkg::OFF_ANALOG_INPUT_DISABLE, 8'h0F);
    settle();
    `CHK(O_DIG_IN_EN, 8'h0F)
    `CHK(O_DIG_IN, 8'h0C)
    rchk(port0_pkg::OFF_DATA_LATCH, 1'b0, 8'h0C);
  endtask : t_out_in
  task automatic t_periph_standby;
    wok(port0_pkg::OFF_ANALOG_INPUT_DISABLE, 8'hFF);
    I_PERIPH_OE <= 8'h30;
    I_PERIPH_OUT <= 8'h20;
    ext_oe <= 8'hC0;
    ext_val <= 8'h80;
    settle();
    `CHK({O_PIN_OE, O_PIN_OUT & 8'h30}, 16'h3F20)
    rchk(port0_pkg::OFF_DATA_LATCH, 1'b0, 8'hAC);
    rchk(port0_pkg::OFF_DATA_LATCH, 1'b1, 8'h3C);
    I_PERIPH_OE <= 8'h00;
    I_STANDBY_PIN_STATE_SELECT <= 1'b1;
    I_STOP_OR_WATCH <= 1'b1;
    I_EXT_IRQ_ENABLE <= 8'h80;
    settle();
    `CHK({O_PIN_OE, O_EXT_IRQ_LEVEL}, 16'h0080)
    `CHK(O_DIG_IN, 8'h80)
    I_STOP_OR_WATCH <= 1'b0;
    wr(12'h020, 8'h5A, r);
    `CHK(r, port0_pkg::RESP_SLVERR)
    rd(12'h020, 1'b0, d, r);
    `CHK({r, d}, {port0_pkg::RESP_SLVERR, 32'h00000000})
    I_WSTRB <= 4'hE;
    wok(port0_pkg::OFF_DIRECTION, 8'hFF);
    I_WSTRB <= 4'hF;
    rchk(port0_pkg::OFF_DIRECTION, 1'b0, 8'h0F);
  endtask : t_periph_standby
  initial
  begin
    I_CLK_SYS = 1'b0;
    forever #20 I_CLK_SYS = ~I_CLK_SYS;
  end
  initial
  begin
    I_RST = 1'b1;
    {I_AWVALID, I_WVALID, I_BREADY, I_ARVALID, I_RREADY} = 5'h00;
    {I_STANDBY_PIN_STATE_SELECT, I_STOP_OR_WATCH, I_AWADDR, I_ARADDR, I_ARPROT} = 29'h0;
    {I_WDATA, I_PERIPH_OE, I_PERIPH_OUT, I_EXT_IRQ_ENABLE, ext_val, ext_oe} = 72'h0;
    I_WSTRB = 4'hF;
    repeat (5) @(posedge I_CLK_SYS);
    I_RST <= 1'b0;
    @(posedge I_CLK_SYS);
    t_out_in();
    t_periph_standby();
    results();
  end
  initial
  begin
    repeat (3000) @(posedge I_CLK_SYS);
    fails++;
    results();
  end
endmodule : port0_gpio_test
`default_nettype wire

// [port0_pin_model.sv]
// external pins: device driver, outside driver, pull-up or floating
`timescale 1ns/100ps
`default_nettype none
module port0_pin_model
(
  input wire logic i_clk,
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_oe,
  input wire logic [7:0] i_pullup,
  input wire logic [7:0] i_ext_val,
  input wire logic [7:0] i_ext_oe,
  output logic [7:0] o_level
);
  logic [7:0] last_q = 8'h00;
  always_comb
  begin
    for (int n = 0; n < 8; n++)
      o_level[n] = i_oe[n] ? i_out[n] : i_ext_oe[n] ? i_ext_val[n] :
                   i_pullup[n] ? 1'b1 : ~last_q[n];
  end
  // a floating pin keeps showing the inverse of its last driven level
  always_ff @(posedge i_clk)
  begin
    for (int n = 0; n < 8; n++)
    begin
      if (i_oe[n] || i_ext_oe[n] || i_pullup[n])
      begin
        last_q[n] <= o_level[n];
      end
    end
  end
endmodule : port0_pin_model
`default_nettype wire

// [port0_pin_mux.sv]
// per-pin driver selection, pull-up and input gating
`timescale 1ns/100ps
`default_nettype none
module port0_pin_mux
(
  input wire logic i_latch,
  input wire logic i_direction,
  input wire logic i_pullup_enable,
  input wire logic i_analog_disable,
  input wire logic i_periph_oe,
  input wire logic i_periph_out,
  input wire logic i_standby_hiz,
  input wire logic i_irq_enable,
  input wire logic i_pin_level,
  output logic o_out,
  output logic o_oe,
  output logic o_pullup,
  output logic o_dig_in_en,
  output logic o_irq_level
);
  logic drive_en;
  logic drive_val;
  logic keep_input;

  always_comb
  begin
    keep_input = !i_standby_hiz || i_irq_enable;
    // peripheral wins over the latch
    drive_val = i_periph_oe ? i_periph_out : i_latch;
    drive_en = (i_periph_oe || i_direction) && !i_standby_hiz;
    o_out = drive_val;
    o_oe = drive_en;
    // pull-up cut while driving low
    o_pullup = i_pullup_enable && !(drive_en && !drive_val);
    // digital path blocked when analog selected
    o_dig_in_en = i_analog_disable && keep_input;
    // interrupt sees pin regardless of port setup, but reads 0 in standby unless its irq is enabled
    o_irq_level = keep_input ? i_pin_level : 1'b0;
  end
endmodule : port0_pin_mux
`default_nettype wire

// [port0_pin_sync.sv]
// three-stage synchroniser with agreement filter for one pin
`timescale 1ns/100ps
`default_nettype none
module port0_pin_sync
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_async,
  output logic o_level
);
  typedef struct packed {
    logic [port0_pkg::SYNC_STAGES-1:0] chain;
    logic level;
  } sync_state_s;

  sync_state_s state_q;
  sync_state_s state_d;

  always_comb
  begin
    state_d = state_q;
    state_d.chain = {state_q.chain[port0_pkg::SYNC_STAGES-2:0], i_async};
    if (state_q.chain[1] == state_q.chain[2])
    begin
      state_d.level = state_q.chain[2];
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign o_level = state_q.level;
endmodule : port0_pin_sync
`default_nettype wire

// [port0_pkg.sv]
// shared constants and carrier types for the port 0 block
package port0_pkg;
  localparam int unsigned PIN_COUNT = 8;
  localparam logic [11:0] OFF_DATA_LATCH = 12'h000;
  localparam logic [11:0] OFF_DIRECTION = 12'h004;
  localparam logic [11:0] OFF_PULLUP_ENABLE = 12'h008;
  localparam logic [11:0] OFF_ANALOG_INPUT_DISABLE = 12'h00C;
  localparam logic [11:0] OFF_PIN_LEVEL = 12'h010;
  localparam logic [11:0] OFF_RMW_STATUS = 12'h014;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int unsigned SYNC_STAGES = 3;
  localparam int unsigned ADDR_LSB = 2;
  localparam int unsigned RMW_BIT = 0;

  typedef struct packed {
    logic [7:0] data_latch;
    logic [7:0] direction;
    logic [7:0] pullup_enable;
    logic [7:0] analog_input_disable_low;
  } port_regs_s;

  typedef struct packed {
    logic [7:0] out_value;
    logic [7:0] out_enable;
    logic [7:0] pullup_on;
    logic [7:0] digital_input_enable;
    logic [7:0] ext_irq_level;
  } pin_ctrl_s;
endpackage : port0_pkg
